// ==== shared/wdwk_pkg.sv ====
package wdwk_pkg;

  // ==========================================================================
  // Register map of the byte-wide port
  // ==========================================================================
  localparam int          ADDR_W      = 5;
  localparam logic [4:0]  OFS_MONTH   = 5'h05;
  localparam logic [4:0]  OFS_WD_LO   = 5'h0c;
  localparam logic [4:0]  OFS_WD_HI   = 5'h0d;
  localparam logic [4:0]  OFS_CTRL_A  = 5'h0e;
  localparam logic [4:0]  OFS_CTRL_B  = 5'h0f;

  // Second control register fields.
  localparam int B_ADV   = 7;
  localparam int B_XTAL  = 6;
  localparam int B_BURST = 5;
  localparam int B_TPE   = 4;
  localparam int B_TIE   = 3;
  localparam int B_KIE   = 2;
  localparam int B_WDE   = 1;
  localparam int B_WDS   = 0;

  // First control (flag) register fields.
  localparam int A_PAB   = 4;
  localparam int A_TDF   = 3;
  localparam int A_KSF   = 2;
  localparam int A_WDF   = 1;
  localparam int A_INTERRUPT_PENDING_FLAG  = 0;

  // Oscillator stop bit in the month register.
  localparam int M_OSC   = 7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]  CTRL_B_RST  = 8'h00;
  localparam logic [7:0]  WD_RST      = 8'h00;
  localparam logic [15:0] BCD_ZERO    = 16'h0000;
  localparam logic [15:0] BCD_ONE     = 16'h0001;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam longint CLK_HZ              = 50000000;
  localparam longint TICK_HZ             = 100;
  localparam int     TICK_CYCLES         = int'(CLK_HZ / TICK_HZ);
  localparam int     TICKS_PER_SEC       = 100;
  localparam longint RESET_PULSE_TIME_US = 200;
  localparam int     RESET_PULSE_CYCLES  = int'((RESET_PULSE_TIME_US * CLK_HZ) / 1000000);
  localparam longint KEY_PULSE_MIN_NS    = 100;
  localparam int     KEY_PULSE_CYCLES    =
    int'((KEY_PULSE_MIN_NS * CLK_HZ + 999999999) / 1000000000);

endpackage

// ==== src/wdwk_bcd_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module wdwk_bcd_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Control
  input  wire logic        tick,
  input  wire logic        reload,
  input  wire logic [15:0] period,
  // Event
  output logic             timeout
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        timeout;
  } wdwk_tmr_t;

  wdwk_tmr_t s;
  wdwk_tmr_t next_s;

  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (r[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          borrow      = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Down-counter
  // ==========================================================================
  always_comb begin
    next_s         = s;
    next_s.timeout = 1'b0;
    if (reload) begin
      next_s.cnt = period;
    end else if (tick && period != wdwk_pkg::BCD_ZERO) begin
      // A count of one (or zero) on a tick of a live period is treated as expiry, so a period of N expires on the Nth tick.
      if (s.cnt <= wdwk_pkg::BCD_ONE) begin
        next_s.timeout = 1'b1;
        next_s.cnt     = period;
      end else begin
        next_s.cnt = bcd_dec(s.cnt);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign timeout = s.timeout;

  chk_zero_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (period == 16'h0000) |=> !timeout)
    else $error("timeout with a zero period");

  chk_reload_restart: assert property (@(posedge clk) disable iff (!reset_n)
    (reload && period > 16'h0001) |=> !timeout ##1 !timeout)
    else $error("timeout right after a reload");

endmodule

`default_nettype wire

// ==== src/wdwk_top.sv ====
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - Clock advances per second only when enabled
// - Advance enable bit changed only by software
// - Crystal select bit chooses oscillator load
// - Burst bit enables extended RAM autoincrement
// - Alarm with power enable requests power
// - Alarm sets interrupt only with enable
// - Kickstart while unpowered requests power, later interrupt
// - Enabled kickstart flag drives interrupt and power
// - Power-on reset clears watchdog enable, steering
// - Steering picks interrupt or reset pulse
// - Period is four BCD digits, 10ms steps
// - Every timeout reloads and sets watchdog flag
// - Period register write reloads the counter
// - Repetitive mode interrupts; flag read clears it
// - Single-shot pulses reset and clears enable
// - Both period registers zero disables timer
// - Alarm wakeup only with advance on, oscillator running
// - Alarm match wakes system regardless interrupt enable
// - Long enough kickstart low sets flag; power only with kickstart enable
// - Oscillator stop bit halts the oscillator
// - Interrupt flag is OR of enabled events; the watchdog flag only counts in repetitive mode, not single-shot
// - Power-active bit cleared by wake events
module wdwk_top #(
  parameter int TICK_CYCLES        = wdwk_pkg::TICK_CYCLES,
  parameter int RESET_PULSE_CYCLES = wdwk_pkg::RESET_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // Byte-wide register port
  input  wire logic [wdwk_pkg::ADDR_W-1:0] addr,
  input  wire logic                        cs_n,
  input  wire logic                        oe_n,
  input  wire logic                        we_n,
  input  wire logic [7:0]                  data_in,
  output logic      [7:0]                  data_out,
  output logic                             data_oe,
  // Supplies and wake inputs
  input  wire logic                        main_supply,
  input  wire logic                        aux_battery,
  input  wire logic                        key_wake_pin_n,
  input  wire logic                        alarm_match,
  // Open-drain pins, driven low while enabled; reset_out_n is driven both high and low
  output logic                             power_on_request_n,
  output logic                             power_on_request_oe,
  output logic                             irq_n,
  output logic                             irq_oe,
  output logic                             reset_out_n,
  // Control towards the rest of the clock
  output logic                             second_pulse,
  output logic                             osc_run,
  output logic                             crystal_load_sel,
  output logic                             ram_autoinc_en
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int RST_W  = $clog2(RESET_PULSE_CYCLES + 1);
  localparam int KEY_W  = $clog2(wdwk_pkg::KEY_PULSE_CYCLES + 1);
  localparam int SEC_W  = $clog2(wdwk_pkg::TICKS_PER_SEC + 1);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [RST_W-1:0]  RST_LOAD  = RST_W'(RESET_PULSE_CYCLES);
  localparam logic [KEY_W-1:0]  KEY_LAST  = KEY_W'(wdwk_pkg::KEY_PULSE_CYCLES - 1);
  localparam logic [KEY_W-1:0]  KEY_SAT   = KEY_W'(wdwk_pkg::KEY_PULSE_CYCLES);
  localparam logic [SEC_W-1:0]  SEC_LAST  = SEC_W'(wdwk_pkg::TICKS_PER_SEC - 1);

  typedef struct packed {
    logic [7:0]        wd_lo;
    logic [7:0]        wd_hi;
    logic [7:0]        ctrl_b;
    logic              osc_stop;
    logic              power_active_bar;
    logic              alarm_match_flag;
    logic              key_wake_flag;
    logic              dog_timeout_flag;
    logic              wr_prev;
    logic              rd_a;
    logic [TICK_W-1:0] presc;
    logic [SEC_W-1:0]  centi;
    logic [KEY_W-1:0]  key_cnt;
    logic [RST_W-1:0]  rst_cnt;
    logic [7:0]        rdata;
    logic              rdata_oe;
    logic              irq_oe;
    logic              pwr_oe;
    logic              rst_out_n;
    logic              second_pulse;
    logic              reload;
  } wdwk_state_t;

  wdwk_state_t s;
  wdwk_state_t next_s;

  logic       dog_timeout;
  logic       tick;
  logic       wr_now;
  logic       wr_take;
  logic       rd_a_now;
  logic       rd_now;
  logic       interrupt_pending_flag;
  logic       dog_enable;
  logic       dog_steer;
  logic [7:0] ctrl_a;

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Writes are taken once, in the first cycle of a write strobe, so a long
  // strobe cannot reload the watchdog over and over.
  assign wr_now     = !cs_n && !we_n;
  assign wr_take    = wr_now && !s.wr_prev;
  assign rd_now     = !cs_n && !oe_n && we_n;
  assign rd_a_now   = rd_now && addr == wdwk_pkg::OFS_CTRL_A;
  assign dog_enable = s.ctrl_b[wdwk_pkg::B_WDE];
  assign dog_steer  = s.ctrl_b[wdwk_pkg::B_WDS];
  assign tick       = !s.osc_stop && s.presc == TICK_LAST;

  // In single-shot mode the watchdog timeout pulses the reset pin low instead of
  // the interrupt, so it stays off the interrupt sum there.
  assign interrupt_pending_flag = (s.alarm_match_flag && s.ctrl_b[wdwk_pkg::B_TIE])
             || (s.key_wake_flag && s.ctrl_b[wdwk_pkg::B_KIE])
             || (s.dog_timeout_flag && dog_enable && !dog_steer);

  always_comb begin
    ctrl_a                  = 8'h00;
    ctrl_a[wdwk_pkg::A_PAB]  = s.power_active_bar;
    ctrl_a[wdwk_pkg::A_TDF]  = s.alarm_match_flag;
    ctrl_a[wdwk_pkg::A_KSF]  = s.key_wake_flag;
    ctrl_a[wdwk_pkg::A_WDF]  = s.dog_timeout_flag;
    ctrl_a[wdwk_pkg::A_INTERRUPT_PENDING_FLAG] = interrupt_pending_flag;
  end

  // ==========================================================================
  // Watchdog counter
  // ==========================================================================
  wdwk_bcd_timer u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (tick),
    .reload  (s.reload),
    .period  ({s.wd_hi, s.wd_lo}),
    .timeout (dog_timeout)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_s              = s;
    next_s.wr_prev      = wr_now;
    next_s.rd_a         = rd_a_now;
    next_s.reload       = 1'b0;
    next_s.second_pulse = 1'b0;

    // Timebase: the prescaler stands still while the oscillator is stopped.
    if (!s.osc_stop) begin
      next_s.presc = (s.presc == TICK_LAST) ? '0 : s.presc + 1'b1;
    end
    if (tick) begin
      next_s.centi = (s.centi == SEC_LAST) ? '0 : s.centi + 1'b1;
      if (s.centi == SEC_LAST && s.ctrl_b[wdwk_pkg::B_ADV]) begin
        next_s.second_pulse = 1'b1;
      end
    end

    // Read data is registered from the address of the current access.
    next_s.rdata_oe = rd_now;
    case (addr)
      wdwk_pkg::OFS_MONTH:  next_s.rdata = {s.osc_stop, 7'h00};
      wdwk_pkg::OFS_WD_LO:  next_s.rdata = s.wd_lo;
      wdwk_pkg::OFS_WD_HI:  next_s.rdata = s.wd_hi;
      wdwk_pkg::OFS_CTRL_A: next_s.rdata = ctrl_a;
      wdwk_pkg::OFS_CTRL_B: next_s.rdata = s.ctrl_b;
      default:              next_s.rdata = 8'h00;
    endcase

    // Flags clear when a read of the flag register ends.
    if (s.rd_a && !rd_a_now) begin
      next_s.alarm_match_flag = 1'b0;
      next_s.key_wake_flag = 1'b0;
      next_s.dog_timeout_flag = 1'b0;
    end

    if (wr_take) begin
      case (addr)
        wdwk_pkg::OFS_MONTH: begin
          next_s.osc_stop = data_in[wdwk_pkg::M_OSC];
        end
        wdwk_pkg::OFS_WD_LO: begin
          next_s.wd_lo  = data_in;
          next_s.reload = 1'b1;
        end
        wdwk_pkg::OFS_WD_HI: begin
          next_s.wd_hi  = data_in;
          next_s.reload = 1'b1;
        end
        wdwk_pkg::OFS_CTRL_A: begin
          next_s.power_active_bar = data_in[wdwk_pkg::A_PAB];
          next_s.key_wake_flag = data_in[wdwk_pkg::A_KSF];
          if (!data_in[wdwk_pkg::A_TDF]) begin
            next_s.alarm_match_flag = 1'b0;
          end
          if (!data_in[wdwk_pkg::A_WDF]) begin
            next_s.dog_timeout_flag = 1'b0;
          end
        end
        wdwk_pkg::OFS_CTRL_B: begin
          // Only this write path touches the advance enable bit.
          next_s.ctrl_b = data_in;
        end
        default: begin
        end
      endcase
    end

    // Kickstart: the pin is watched while the aux battery holds the part and
    // main supply is away; a low of the minimum width sets the flag once.
    if (key_wake_pin_n || main_supply || !aux_battery) begin
      next_s.key_cnt = '0;
    end else if (s.key_cnt != KEY_SAT) begin
      next_s.key_cnt = s.key_cnt + 1'b1;
      if (s.key_cnt == KEY_LAST) begin
        next_s.key_wake_flag = 1'b1;
      end
    end

    // Alarm match counts only while the clock advances and the oscillator
    // runs, and sets the flag whatever the interrupt enable holds.
    if (alarm_match && s.ctrl_b[wdwk_pkg::B_ADV] && !s.osc_stop) begin
      next_s.alarm_match_flag = 1'b1;
    end

    // Each timeout flags, whatever the enable holds; the set wins over any
    // clear in the same cycle.
    if (dog_timeout) begin
      next_s.dog_timeout_flag = 1'b1;
      if (dog_enable && dog_steer) begin
        next_s.rst_cnt      = RST_LOAD;
        next_s.ctrl_b[wdwk_pkg::B_WDE] = 1'b0;
      end
    end
    if (s.rst_cnt != '0) begin
      next_s.rst_cnt = s.rst_cnt - 1'b1;
    end
    next_s.rst_out_n = (next_s.rst_cnt == '0);

    // Wake events pull the power request active.
    if ((s.alarm_match_flag && s.ctrl_b[wdwk_pkg::B_TPE])
        || (s.key_wake_flag && s.ctrl_b[wdwk_pkg::B_KIE])) begin
      next_s.power_active_bar = 1'b0;
    end

    next_s.pwr_oe = !s.power_active_bar;
    // The interrupt pin stays released until main supply is up.
    next_s.irq_oe = interrupt_pending_flag && main_supply;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Period registers and the remaining control bits have no defined power-up
  // value; they come up at zero, which leaves the watchdog idle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s           <= '0;
      s.wd_lo     <= wdwk_pkg::WD_RST;
      s.wd_hi     <= wdwk_pkg::WD_RST;
      s.ctrl_b    <= wdwk_pkg::CTRL_B_RST;
      s.rst_out_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign data_out            = s.rdata;
  assign data_oe             = s.rdata_oe;
  assign power_on_request_n  = 1'b0;
  assign power_on_request_oe = s.pwr_oe;
  assign irq_n               = 1'b0;
  assign irq_oe              = s.irq_oe;
  assign reset_out_n         = s.rst_out_n;
  assign second_pulse        = s.second_pulse;
  assign osc_run             = !s.osc_stop;
  assign crystal_load_sel    = s.ctrl_b[wdwk_pkg::B_XTAL];
  assign ram_autoinc_en      = s.ctrl_b[wdwk_pkg::B_BURST];

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_advance_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !s.ctrl_b[wdwk_pkg::B_ADV] |=> !second_pulse)
    else $error("second pulse while advance disabled");

  chk_irq_follows: assert property (@(posedge clk) disable iff (!reset_n)
    (interrupt_pending_flag && main_supply) |=> irq_oe)
    else $error("interrupt pin not driven for pending flag");

  chk_irq_gated: assert property (@(posedge clk) disable iff (!reset_n)
    (!s.ctrl_b[wdwk_pkg::B_TIE] && !s.ctrl_b[wdwk_pkg::B_KIE]
     && !dog_enable) |=> !irq_oe)
    else $error("interrupt with every source disabled");

  chk_pwr_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (s.alarm_match_flag && s.ctrl_b[wdwk_pkg::B_TPE]) |=> ##1 power_on_request_oe)
    else $error("alarm wake did not request power");

  chk_single_shot: assert property (@(posedge clk) disable iff (!reset_n)
    (dog_timeout && dog_enable && dog_steer)
      |=> (!reset_out_n && !s.ctrl_b[wdwk_pkg::B_WDE]))
    else $error("single-shot timeout without reset pulse");

  chk_flag_wins: assert property (@(posedge clk) disable iff (!reset_n)
    dog_timeout |=> s.dog_timeout_flag)
    else $error("watchdog flag lost on timeout");

endmodule

`default_nettype wire

// ==== sim/wdwk_host.sv ====
`timescale 1ns/1ps
`default_nettype none

// ====================
// Host on the byte-wide port
// ====================
module wdwk_host (
  // Clock
  input  wire logic       clk,
  // Bus towards the device
  output logic [4:0]      addr,
  output logic            cs_n,
  output logic            oe_n,
  output logic            we_n,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  initial begin
    addr    = 5'h00;
    cs_n    = 1'b1;
    oe_n    = 1'b1;
    we_n    = 1'b1;
    data_in = 8'h00;
  end

  // Write data is inverted once released so a stale byte can never look valid.
  // The idle cycle at the end is the strobe release that writes need between them.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    addr    = a;
    data_in = d;
    cs_n    = 1'b0;
    we_n    = 1'b0;
    @(negedge clk);
    cs_n    = 1'b1;
    we_n    = 1'b1;
    data_in = ~d;
    @(negedge clk);
  endtask

  // The trailing idle cycle lets the read-clear of the flags land.
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic o);
    @(negedge clk);
    addr = a;
    cs_n = 1'b0;
    oe_n = 1'b0;
    @(negedge clk);
    @(negedge clk);
    d    = data_out;
    o    = data_oe;
    cs_n = 1'b1;
    oe_n = 1'b1;
    addr = ~a;
    @(negedge clk);
  endtask
endmodule

`default_nettype wire

// ==== sim/test_wdwk_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end

module test_wdwk_top;
  localparam int TICKS = 10;
  localparam int PULSE = 8;
  localparam logic [15:0] PER [3] = '{16'h0005, 16'h0010, 16'h0100};
  localparam int TK [3] = '{5, 10, 100};
  logic clk, reset_n, cs_n, oe_n, we_n, data_oe, main_supply, aux_battery;
  logic key_wake_pin_n, alarm_match, pwr_oe, irq_oe, reset_out_n, second_pulse;
  logic osc_run, xtal, autoinc, pwr_pin_n, irq_pin_n;
  logic [4:0] addr;
  logic [7:0] data_in, data_out;
  int miscompares, tests_run, n;
  int cycles = 0;

  wdwk_top #(.TICK_CYCLES(TICKS), .RESET_PULSE_CYCLES(PULSE)) i_dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .main_supply(main_supply),
    .aux_battery(aux_battery), .key_wake_pin_n(key_wake_pin_n), .alarm_match(alarm_match),
    .power_on_request_n(pwr_pin_n), .power_on_request_oe(pwr_oe), .irq_n(irq_pin_n),
    .irq_oe(irq_oe),
    .reset_out_n(reset_out_n), .second_pulse(second_pulse), .osc_run(osc_run),
    .crystal_load_sel(xtal), .ram_autoinc_en(autoinc));

  wdwk_host i_host (.clk(clk), .addr(addr), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask

  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       o;
    i_host.rd(a, d, o);
    `CHK(o, 1'b1)
    `CHK(d, e)
  endtask

  // ====================
  // Waiting and counting on outputs
  // ====================
  function automatic logic sig(input int s);
    case (s)
      0: sig = irq_oe;
      1: sig = ~reset_out_n;
      default: sig = second_pulse;
    endcase
  endfunction

  task automatic wait_sig(input int s, output int k);
    k = 0;
    while (sig(s) !== 1'b1 && k < 1200) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic count_sp(input int c, output int k);
    k = 0;
    repeat (c) begin
      @(negedge clk);
      if (second_pulse === 1'b1) k++;
    end
  endtask

  task automatic alarm;
    alarm_match = 1'b1;
    idle(1);
    alarm_match = 1'b0;
    idle(3);
  endtask

  task automatic key(input int c);
    key_wake_pin_n = 1'b0;
    idle(c);
    key_wake_pin_n = 1'b1;
    idle(3);
  endtask

  // ====================
  // Main sequence
  // ====================
  initial begin
    miscompares = 0;
    tests_run = 0;
    reset_n = 1'b0;
    main_supply = 1'b1;
    aux_battery = 1'b1;
    key_wake_pin_n = 1'b1;
    alarm_match = 1'b0;
    idle(2);
    reset_n = 1'b1;
    rc(5'h0f, 8'h00);
    rc(5'h0c, 8'h00);
    rc(5'h0d, 8'h00);
    i_host.wr(5'h1f, 8'h5a);
    rc(5'h1f, 8'h00);
    `CHK(osc_run, 1'b1)
    `CHK(reset_out_n, 1'b1)
    `CHK({pwr_pin_n, irq_pin_n}, 2'b00)
    i_host.wr(5'h0f, 8'hff);
    rc(5'h0f, 8'hff);
    `CHK({xtal, autoinc}, 2'b11)
    i_host.wr(5'h0f, 8'h40);
    `CHK({xtal, autoinc}, 2'b10)
    i_host.wr(5'h0f, 8'h80);
    count_sp(2000, n);
    `CHK(n, 2)
    i_host.wr(5'h05, 8'h80);
    `CHK(osc_run, 1'b0)
    count_sp(1200, n);
    `CHK(n, 0)
    rc(5'h05, 8'h80);
    i_host.wr(5'h05, 8'h00);
    i_host.wr(5'h0f, 8'h00);
    count_sp(1200, n);
    `CHK(n, 0)
    rc(5'h0f, 8'h00);
    i_host.wr(5'h0f, 8'h02);
    for (int i = 0; i < 3; i++) begin
      i_host.wr(5'h0d, PER[i][15:8]);
      i_host.wr(5'h0c, PER[i][7:0]);
      wait_sig(0, n);
      `CHK(n >= TK[i] * TICKS - 12 && n <= TK[i] * TICKS + 6, 1'b1)
      rc(5'h0e, 8'h03);
      idle(2);
      `CHK(irq_oe, 1'b0)
    end
    i_host.wr(5'h0d, 8'h00);
    repeat (5) begin
      i_host.wr(5'h0c, 8'h05);
      idle(25);
      `CHK(irq_oe, 1'b0)
    end
    wait_sig(0, n);
    `CHK(n <= 56, 1'b1)
    rc(5'h0e, 8'h03);
    i_host.wr(5'h0c, 8'h00);
    idle(120);
    rc(5'h0e, 8'h00);
    i_host.wr(5'h0f, 8'h00);
    i_host.wr(5'h0c, 8'h05);
    idle(70);
    `CHK(irq_oe, 1'b0)
    rc(5'h0e, 8'h02);
    idle(55);
    rc(5'h0e, 8'h02);
    i_host.wr(5'h0f, 8'h03);
    wait_sig(1, n);
    `CHK(n <= 60, 1'b1)
    `CHK(irq_oe, 1'b0)
    n = 0;
    while (reset_out_n === 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, PULSE)
    rc(5'h0f, 8'h01);
    rc(5'h0e, 8'h02);
    i_host.wr(5'h0c, 8'h00);
    i_host.wr(5'h0e, 8'h10);
    idle(2);
    `CHK(pwr_oe, 1'b0)
    i_host.wr(5'h0f, 8'h04);
    main_supply = 1'b0;
    key(4);
    `CHK(pwr_oe, 1'b0)
    key(5);
    `CHK(pwr_oe, 1'b1)
    `CHK(irq_oe, 1'b0)
    main_supply = 1'b1;
    idle(2);
    `CHK(irq_oe, 1'b1)
    rc(5'h0e, 8'h05);
    i_host.wr(5'h0f, 8'h00);
    i_host.wr(5'h0e, 8'h14);
    idle(3);
    `CHK({pwr_oe, irq_oe}, 2'b00)
    i_host.wr(5'h0f, 8'h04);
    idle(3);
    `CHK({pwr_oe, irq_oe}, 2'b11)
    rc(5'h0e, 8'h05);
    i_host.wr(5'h0e, 8'h10);
    i_host.wr(5'h0f, 8'h08);
    alarm();
    `CHK(irq_oe, 1'b0)
    rc(5'h0e, 8'h10);
    i_host.wr(5'h0f, 8'h88);
    alarm();
    `CHK({pwr_oe, irq_oe}, 2'b01)
    rc(5'h0e, 8'h19);
    i_host.wr(5'h0f, 8'h90);
    alarm();
    `CHK({pwr_oe, irq_oe}, 2'b10)
    rc(5'h0e, 8'h08);
    i_host.wr(5'h05, 8'h80);
    alarm();
    rc(5'h0e, 8'h00);
    i_host.wr(5'h05, 8'h00);
    test_done();
  end
endmodule

`default_nettype wire
